// ---- inc/scf_frontend_regs.vh ----
// Constants of the serial command and integrity front end.
// Assumes the includer works at a 250 MHz clock that doubles as the master clock.
`ifndef SCF_FRONTEND_REGS_VH
`define SCF_FRONTEND_REGS_VH

// ****************************************
// Command words and fixed responses
// ****************************************
`define SCF_CMD_NULL       16'h0000
`define SCF_CMD_RESET      16'h0011
`define SCF_CMD_STANDBY    16'h0022
`define SCF_CMD_WAKEUP     16'h0033
`define SCF_CMD_LOCK       16'h0555
`define SCF_CMD_UNLOCK     16'h0655
`define SCF_OP_REGISTER_READ_CMD        3'h5
`define SCF_OP_REGISTER_WRITE_CMD        3'h3
`define SCF_ACK_REGISTER_READ_CMD       3'h7
`define SCF_ACK_REGISTER_WRITE_CMD       3'h2
`define SCF_RESP_RESET_OK  16'hFF23
`define SCF_RESP_RESET_BAD 16'h0011

// ****************************************
// Integrity check
// ****************************************
`define SCF_CRC_SEED       16'hFFFF
`define SCF_POLY_CCITT     16'h1021
`define SCF_POLY_ANSI      16'h8005

// ****************************************
// Status word layout
// ****************************************
`define SCF_ST_LOCK        15
`define SCF_ST_CRC_ERR     12
`define SCF_ST_STANDBY     10

// ****************************************
// Word length field codes
// ****************************************
`define SCF_WL_16          2'h0
`define SCF_WL_24          2'h1
`define SCF_WL_32_ZERO     2'h2
`define SCF_WL_32_SIGN     2'h3

// ****************************************
// Frame layout and timing
// ****************************************
`define SCF_DATA_CRC_IDX   8'h04
`define SCF_TIMEOUT_MCLK   32768
`define SCF_MCLK_PER_CLK   1
`define SCF_TIMEOUT_CYC    (`SCF_TIMEOUT_MCLK / `SCF_MCLK_PER_CLK)
`define SCF_FIFO_DEPTH     8

`endif

// ---- core/scf_frontend.v ----
// Serial command interpreter with input/output check words, plus the sample FIFO.
// Assumes the register map lives outside on the same clock and answers reads
// combinationally; the serial pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`include "scf_frontend_regs.vh"

// ****************************************
// Sample FIFO
// ****************************************
module scf_fifo #(
  parameter WIDTH = 75,
  parameter DEPTH = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             resetn,
  // Filling side
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output reg              out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam AW = $clog2(DEPTH);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;
  reg  [AW:0]     nxt_count;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rd_ptr_ff];

  always @* begin
    nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff  <= nxt_count;
      in_ready  <= (nxt_count != DEPTH[AW:0]);
      out_valid <= (nxt_count != {(AW+1){1'b0}});
    end
  end
endmodule

module scf_frontend #(
  parameter TIMEOUT_CYCLES = `SCF_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // Serial pins
  input  wire        cs_n,
  input  wire        sclk,
  input  wire        din,
  output reg         dout,
  output reg         dout_oe,
  // Configuration
  input  wire [1:0]  word_length_field,
  input  wire        rx_crc_enable,
  input  wire        crc_type_ansi,
  input  wire        timeout_enable,
  input  wire [2:0]  data_ready_flags,
  // Conversion samples, three 25-bit raw channels
  input  wire        sample_valid,
  output wire        sample_ready,
  input  wire [74:0] sample_data,
  // External register map
  output reg  [5:0]  reg_rd_addr,
  input  wire [15:0] reg_rd_data,
  output reg         reg_wr_en,
  output reg  [5:0]  reg_wr_addr,
  output reg  [15:0] reg_wr_data,
  input  wire        reg_wr_ok,
  // Device state
  output reg         soft_reset,
  output reg         standby,
  output reg         locked,
  output reg         crc_err
);
  // Response kinds, one-hot
  localparam RK_STATUS = 4'b0001;
  localparam RK_FIXED  = 4'b0010;
  localparam RK_REG    = 4'b0100;
  localparam RK_MREG   = 4'b1000;

  // ****************************************
  // Helpers
  // ****************************************
  function [15:0] crc_step;
    input [15:0] crc;
    input        bit_in;
    input        ansi;
    begin
      crc_step = {crc[14:0], 1'b0} ^
                 ((crc[15] ^ bit_in) ? (ansi ? `SCF_POLY_ANSI : `SCF_POLY_CCITT)
                                     : 16'h0000);
    end
  endfunction

  function [5:0] word_bits;
    input [1:0] wl;
    begin
      case (wl)
        `SCF_WL_16: word_bits = 6'd16;
        `SCF_WL_24: word_bits = 6'd24;
        default:    word_bits = 6'd32;
      endcase
    end
  endfunction

  function [23:0] saturate;
    input [24:0] raw;
    begin
      if (raw[24] != raw[23]) begin
        saturate = raw[24] ? 24'h80_0000 : 24'h7F_FFFF;
      end else begin
        saturate = raw[23:0];
      end
    end
  endfunction

  function [31:0] fmt_data;
    input [23:0] d;
    input [1:0]  wl;
    begin
      case (wl)
        `SCF_WL_16:      fmt_data = {d[23:8], 16'h0000};
        `SCF_WL_32_SIGN: fmt_data = {{8{d[23]}}, d};
        default:         fmt_data = {d, 8'h00};
      endcase
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg        cs_s1_ff, cs_s2_ff, ck_s1_ff, ck_s2_ff, ck_d_ff, di_s1_ff, di_s2_ff;
  reg        act_ff;
  reg [1:0]  wl_ff;
  reg [5:0]  wb_ff;
  reg [5:0]  ibit_ff;
  reg [7:0]  iwd_ff;
  reg [31:0] iw_ff;
  reg [15:0] icrc_ff;
  reg [5:0]  obit_ff;
  reg [7:0]  owd_ff;
  reg [31:0] ow_ff;
  reg [15:0] ocrc_ff;
  reg [15:0] cmd_ff;
  reg        crc_bad_ff;
  reg [5:0]  wptr_ff;
  reg [6:0]  wcnt_ff;
  reg [3:0]  rkind_ff;
  reg [15:0] resp_ff;
  reg [6:0]  rcnt_ff;
  reg [23:0] ch_ff [0:2];
  reg [15:0] tmo_ff;
  reg        pop_ff;

  wire        rise, fall, cs_low, tmo_hit, frame_end, start, mreg, is_register_write_cmd, is_register_read_cmd;
  wire        complete, allowed;
  wire [7:0]  olast, icrc_idx;
  wire [5:0]  wb_now;
  wire [7:0]  oidx;
  wire [31:0] nw;
  wire [15:0] w16;
  wire [15:0] status_word;
  wire        fifo_valid;
  wire [74:0] fifo_data;
  reg  [31:0] word_out;

  assign rise      = ck_s2_ff & ~ck_d_ff;
  assign fall      = ~ck_s2_ff & ck_d_ff;
  assign cs_low    = ~cs_s2_ff;
  assign tmo_hit   = timeout_enable & act_ff &
                     (tmo_ff == TIMEOUT_CYCLES[15:0] - 16'h0001);
  assign frame_end = act_ff & (cs_s2_ff | tmo_hit);
  assign start     = ~act_ff & cs_low & rise;
  assign mreg      = rkind_ff[3];
  assign olast     = mreg ? {1'b0, rcnt_ff} + 8'h02 : `SCF_DATA_CRC_IDX;
  assign is_register_write_cmd   = (cmd_ff[15:13] == `SCF_OP_REGISTER_WRITE_CMD);
  assign is_register_read_cmd   = (cmd_ff[15:13] == `SCF_OP_REGISTER_READ_CMD);
  assign icrc_idx  = is_register_write_cmd ? {1'b0, cmd_ff[6:0]} + 8'h02 : 8'h01;
  assign complete  = (iwd_ff > olast) & (iwd_ff > icrc_idx);
  assign allowed   = ~locked | is_register_read_cmd | (cmd_ff == `SCF_CMD_NULL) |
                     (cmd_ff == `SCF_CMD_UNLOCK);
  assign wb_now    = act_ff ? wb_ff : word_bits(word_length_field);
  assign oidx      = act_ff ? owd_ff : 8'h00;
  assign nw        = {iw_ff[30:0], di_s2_ff};
  assign w16       = nw[wb_ff - 6'd1 -: 16];
  assign status_word = {locked, 2'b00, crc_err, 1'b0, standby, 7'h00,
                        data_ready_flags};

  // ****************************************
  // Output word selection
  // ****************************************
  always @* begin
    if (oidx == 8'h00) begin
      case (rkind_ff)
        RK_STATUS: word_out = {status_word, 16'h0000};
        RK_REG:    word_out = {reg_rd_data, 16'h0000};
        RK_MREG:   word_out = {`SCF_ACK_REGISTER_READ_CMD, resp_ff[12:0], 16'h0000};
        default:   word_out = {resp_ff, 16'h0000};
      endcase
    end else if (oidx == olast) begin
      word_out = {ocrc_ff, 16'h0000};
    end else if (oidx > olast) begin
      word_out = 32'h0000_0000;
    end else if (mreg) begin
      word_out = {reg_rd_data, 16'h0000};
    end else begin
      word_out = fmt_data(ch_ff[oidx[1:0] - 2'd1], wl_ff);
    end
  end

  // ****************************************
  // Sample buffer
  // ****************************************
  // Samples are only taken at frame start, so a host that stops reading stalls
  // the producer through sample_ready instead of silently dropping results.
  scf_fifo #(
    .WIDTH (75),
    .DEPTH (`SCF_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample_data),
    .out_valid (fifo_valid),
    .out_ready (pop_ff),
    .out_data  (fifo_data)
  );

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      ck_s1_ff <= 1'b0;
      ck_s2_ff <= 1'b0;
      ck_d_ff  <= 1'b0;
      di_s1_ff <= 1'b0;
      di_s2_ff <= 1'b0;
    end else begin
      cs_s1_ff <= cs_n;
      cs_s2_ff <= cs_s1_ff;
      ck_s1_ff <= sclk;
      ck_s2_ff <= ck_s1_ff;
      ck_d_ff  <= ck_s2_ff;
      di_s1_ff <= din;
      di_s2_ff <= di_s1_ff;
    end
  end

  // ****************************************
  // Frame engine
  // ****************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      act_ff      <= 1'b0;
      wl_ff       <= `SCF_WL_24;
      wb_ff       <= 6'd24;
      ibit_ff     <= 6'd0;
      iwd_ff      <= 8'h00;
      iw_ff       <= 32'h0000_0000;
      icrc_ff     <= `SCF_CRC_SEED;
      obit_ff     <= 6'd0;
      owd_ff      <= 8'h00;
      ow_ff       <= 32'h0000_0000;
      ocrc_ff     <= `SCF_CRC_SEED;
      cmd_ff      <= `SCF_CMD_NULL;
      crc_bad_ff  <= 1'b0;
      wptr_ff     <= 6'd0;
      wcnt_ff     <= 7'd0;
      rkind_ff    <= RK_STATUS;
      resp_ff     <= 16'h0000;
      rcnt_ff     <= 7'd0;
      ch_ff[0]    <= 24'h00_0000;
      ch_ff[1]    <= 24'h00_0000;
      ch_ff[2]    <= 24'h00_0000;
      tmo_ff      <= 16'h0000;
      pop_ff      <= 1'b0;
      dout        <= 1'b0;
      dout_oe     <= 1'b0;
      reg_rd_addr <= 6'd0;
      reg_wr_en   <= 1'b0;
      reg_wr_addr <= 6'd0;
      reg_wr_data <= 16'h0000;
      soft_reset  <= 1'b0;
      standby     <= 1'b0;
      locked      <= 1'b0;
      crc_err     <= 1'b0;
    end else begin
      dout_oe    <= cs_low;
      pop_ff     <= 1'b0;
      reg_wr_en  <= 1'b0;
      soft_reset <= 1'b0;
      if (reg_wr_en && reg_wr_ok) begin
        wcnt_ff <= wcnt_ff + 7'd1;
      end
      tmo_ff <= act_ff ? tmo_ff + 16'h0001 : 16'h0000;

      if (frame_end) begin
        // Timeout lands here too: only the reset command judges the partial frame incomplete
        act_ff   <= 1'b0;
        rkind_ff <= RK_STATUS;
        if (crc_bad_ff || !allowed) begin
          rkind_ff <= RK_STATUS;
        end else if (cmd_ff == `SCF_CMD_RESET) begin
          rkind_ff <= RK_FIXED;
          // A frame cut by the timeout never counts as complete
          if (complete && !tmo_hit) begin
            soft_reset <= 1'b1;
            standby    <= 1'b0;
            locked     <= 1'b0;
            crc_err    <= 1'b0;
            resp_ff    <= `SCF_RESP_RESET_OK;
          end else begin
            resp_ff    <= `SCF_RESP_RESET_BAD;
          end
        end else if (cmd_ff == `SCF_CMD_STANDBY || cmd_ff == `SCF_CMD_WAKEUP) begin
          standby  <= (cmd_ff == `SCF_CMD_STANDBY);
          rkind_ff <= RK_FIXED;
          resp_ff  <= cmd_ff;
        end else if (cmd_ff == `SCF_CMD_LOCK || cmd_ff == `SCF_CMD_UNLOCK) begin
          locked   <= (cmd_ff == `SCF_CMD_LOCK);
          rkind_ff <= RK_FIXED;
          resp_ff  <= cmd_ff;
        end else if (is_register_read_cmd) begin
          reg_rd_addr <= cmd_ff[12:7];
          rcnt_ff     <= cmd_ff[6:0];
          resp_ff     <= cmd_ff;
          rkind_ff    <= (cmd_ff[6:0] == 7'd0) ? RK_REG : RK_MREG;
        end else if (is_register_write_cmd) begin
          rkind_ff <= RK_FIXED;
          resp_ff  <= {`SCF_ACK_REGISTER_WRITE_CMD, cmd_ff[12:7], wcnt_ff - 7'd1};
        end
      end else if (cs_low && (act_ff || start) && rise) begin
        if (start) begin
          act_ff     <= 1'b1;
          wl_ff      <= word_length_field;
          wb_ff      <= wb_now;
          ibit_ff    <= 6'd0;
          iwd_ff     <= 8'h00;
          icrc_ff    <= `SCF_CRC_SEED;
          crc_bad_ff <= 1'b0;
          if (fifo_valid && !mreg) begin
            pop_ff   <= 1'b1;
            ch_ff[0] <= saturate(fifo_data[24:0]);
            ch_ff[1] <= saturate(fifo_data[49:25]);
            ch_ff[2] <= saturate(fifo_data[74:50]);
          end
        end
        // Output side: shifts on the rising edge, MSB first
        if (start || obit_ff == 6'd0) begin
          ow_ff <= {word_out[30:0], 1'b0};
          dout  <= word_out[31];
          if (oidx == 8'h00 && rkind_ff == RK_STATUS) begin
            crc_err <= 1'b0;
          end
          if (mreg && oidx != 8'h00 && oidx < olast) begin
            reg_rd_addr <= reg_rd_addr + 6'd1;
          end
        end else begin
          ow_ff <= {ow_ff[30:0], 1'b0};
          dout  <= ow_ff[31];
        end
        if (oidx < olast) begin
          ocrc_ff <= crc_step(start ? `SCF_CRC_SEED : ocrc_ff,
                              (start || obit_ff == 6'd0) ? word_out[31] : ow_ff[31],
                              crc_type_ansi);
        end
        if (start) begin
          obit_ff <= (wb_now == 6'd1) ? 6'd0 : 6'd1;
          owd_ff  <= 8'h00;
        end else if (obit_ff == wb_ff - 6'd1) begin
          obit_ff <= 6'd0;
          owd_ff  <= (owd_ff == 8'hFF) ? owd_ff : owd_ff + 8'h01;
        end else begin
          obit_ff <= obit_ff + 6'd1;
        end
      end else if (act_ff && cs_low && fall) begin
        // Input side: sampled on the falling edge
        iw_ff <= nw;
        if (iwd_ff != icrc_idx || iwd_ff == 8'h00) begin
          icrc_ff <= crc_step(icrc_ff, di_s2_ff, crc_type_ansi);
        end
        if (ibit_ff == wb_ff - 6'd1) begin
          ibit_ff <= 6'd0;
          iwd_ff  <= (iwd_ff == 8'hFF) ? iwd_ff : iwd_ff + 8'h01;
          if (iwd_ff == 8'h00) begin
            cmd_ff  <= w16;
            wptr_ff <= w16[12:7];
            wcnt_ff <= 7'd0;
          end else begin
            if (is_register_write_cmd && !locked && iwd_ff <= {1'b0, cmd_ff[6:0]} + 8'h01) begin
              reg_wr_en   <= 1'b1;
              reg_wr_addr <= wptr_ff;
              reg_wr_data <= w16;
              wptr_ff     <= wptr_ff + 6'd1;
            end
            if (iwd_ff == icrc_idx && rx_crc_enable && w16 != icrc_ff) begin
              crc_bad_ff <= 1'b1;
              crc_err    <= 1'b1;
            end
          end
        end else begin
          ibit_ff <= ibit_ff + 6'd1;
        end
      end
    end
  end
endmodule

// ---- verification/scf_frontend_props.sv ----
// Concurrent checks on the front end's select, write and state outputs.
// Assumes it is bound to scf_frontend and sees only that module's ports.
`timescale 1ns/1ps
module scf_frontend_props #(
  parameter TIMEOUT_CYCLES = 32768
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Pins and state
  input wire cs_n,
  input wire dout_oe,
  input wire reg_wr_en,
  input wire soft_reset,
  input wire standby,
  input wire locked,
  input wire crc_err
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_oe_idle: assert property (cs_n [*4] |-> !dout_oe)
    else $error("dout enabled while deselected");
  a_oe_frame: assert property (!cs_n [*4] |-> dout_oe)
    else $error("dout not enabled in frame");
  a_wr_single: assert property (reg_wr_en |=> !reg_wr_en)
    else $error("write pulse too long");
  a_wr_framed: assert property (cs_n [*8] |-> !reg_wr_en)
    else $error("write outside frame");
  a_rst_pulse: assert property (soft_reset |=> !soft_reset)
    else $error("reset pulse too long");
  a_rst_at_end: assert property (soft_reset |-> cs_n)
    else $error("reset before frame end");
  a_stby_at_end: assert property (!$stable(standby) |-> cs_n)
    else $error("standby changed in frame");
  a_lock_at_end: assert property (!$stable(locked) |-> cs_n)
    else $error("lock changed in frame");
  a_lock_gate: assert property ($rose(standby) |-> !$past(locked))
    else $error("standby taken while locked");
  a_err_in_frame: assert property ($rose(crc_err) |-> dout_oe)
    else $error("check error set outside a frame");
  c_reset: cover property (soft_reset);
  c_write: cover property (reg_wr_en);
  c_err: cover property ($rose(crc_err));
  c_lock: cover property ($rose(locked));
endmodule

bind scf_frontend scf_frontend_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
  .clk(clk), .resetn(resetn), .cs_n(cs_n), .dout_oe(dout_oe), .reg_wr_en(reg_wr_en),
  .soft_reset(soft_reset), .standby(standby), .locked(locked), .crc_err(crc_err)
);

// ---- verification/scf_host_model.sv ----
// Host serial controller model: sends framed words with a check word, records dout.
// Assumes the device samples din on falling sclk and updates dout on rising sclk.
`timescale 1ns/1ps
module scf_host_model (
  // Serial pins
  output reg  cs_n,
  output reg  sclk,
  output reg  din,
  input  wire dout,
  // Configuration
  input  wire ansi
);
  reg     [15:0] tx [0:7];
  reg     [31:0] rx [0:7];
  reg     [15:0] ci;
  reg     [15:0] co;
  integer        i;
  integer        j;
  // ********
  // Check word step, MSB first as shifted
  // ********
  function [15:0] step(input [15:0] c, input b);
    step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? (ansi ? 16'h8005 : 16'h1021) : 16'h0000);
  endfunction
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    for (i = 0; i < 8; i = i + 1)
      tx[i] = 16'h0000;
  end
  // Clock stands low between frames; din flips on release so no stale bit lingers
  task frame(input integer nw, input integer w, input integer ck, input bad);
    reg [31:0] word;
    begin
      ci = 16'hFFFF;
      co = 16'hFFFF;
      cs_n = 1'b0;
      #100;
      for (i = 0; i < nw; i = i + 1) begin
        word = (i == ck) ? {ci ^ {15'h0000, bad}, 16'h0000} : {tx[i], 16'h0000};
        rx[i] = 32'h0000_0000;
        for (j = 0; j < w; j = j + 1) begin
          sclk = 1'b1;
          din = word[31-j];
          if (i < ck)
            ci = step(ci, din);
          #40;
          sclk = 1'b0;
          rx[i][31-j] = dout;
          if (i < nw - 1)
            co = step(co, dout);
          #40;
        end
      end
      cs_n = 1'b1;
      din = ~din;
      #400;
    end
  endtask
endmodule

// ---- verification/scf_frontend_bench.sv ----
// Self-checking bench for the serial command front end.
// Assumes the host model drives the link and a tiny map answers reads from the address.
`timescale 1ns/1ps
`include "scf_frontend_regs.vh"
module scf_frontend_bench;
  reg          clk = 1'b0;
  reg          resetn = 1'b0;
  reg  [1:0]   word_length_field = `SCF_WL_24;
  reg          rx_crc_enable = 1'b0;
  reg          crc_type_ansi = 1'b0;
  reg          timeout_enable = 1'b0;
  reg  [2:0]   data_ready_flags = 3'h5;
  reg          sample_valid = 1'b0;
  reg  [74:0]  sample_data = {25'h1FF_FFFF, 25'h100_0000, 25'h080_0000};
  reg  [21:0]  wr_seen = 22'h00_0000;
  wire         cs_n, sclk, din, dout, dout_oe, sample_ready;
  wire         reg_wr_en, soft_reset, standby, locked, crc_err;
  wire [5:0]   reg_rd_addr, reg_wr_addr;
  wire [15:0]  reg_wr_data;
  wire [15:0]  reg_rd_data = {10'h000, reg_rd_addr} ^ 16'hA5A5;
  // Top address refuses writes, so the written count can fall short
  wire         reg_wr_ok = (reg_wr_addr != 6'h3F);
  integer      resets = 0;
  integer      err_count = 0;
  integer      compares = 0;
  integer      k;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (reg_wr_en === 1'b1)
      wr_seen <= {reg_wr_addr, reg_wr_data};
    if (soft_reset === 1'b1)
      resets <= resets + 1;
  end
  scf_frontend #(.TIMEOUT_CYCLES(4096)) uut (
    .clk(clk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe(dout_oe), .word_length_field(word_length_field), .rx_crc_enable(rx_crc_enable),
    .crc_type_ansi(crc_type_ansi), .timeout_enable(timeout_enable),
    .data_ready_flags(data_ready_flags),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en),
    .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data), .reg_wr_ok(reg_wr_ok),
    .soft_reset(soft_reset), .standby(standby), .locked(locked), .crc_err(crc_err)
  );
  scf_host_model host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .ansi(crc_type_ansi));
  // ********
  // Helpers
  // ********
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  function [15:0] st(input l, input e, input s);
    st = {l, 2'b00, e, 1'b0, s, 7'h00, data_ready_flags};
  endfunction
  function [31:0] dx(input [1:0] wl, input [23:0] v);
    case (wl)
      `SCF_WL_16: dx = {v[23:8], 16'h0000};
      `SCF_WL_32_SIGN: dx = {{8{v[23]}}, v};
      default: dx = {v, 8'h00};
    endcase
  endfunction
  // One frame: command c, first data word d, expected answer e to the previous frame
  task run(input [15:0] c, input [15:0] d, input [15:0] e, input integer nw, input integer ck,
           input bad);
    begin
      host.tx[0] = c;
      host.tx[1] = d;
      host.frame(nw, (word_length_field == `SCF_WL_16) ? 16 :
                 (word_length_field == `SCF_WL_24) ? 24 : 32, ck, bad);
      chk(host.rx[0][31:16], e);
      if (nw > 2)
        chk(host.rx[nw - 1][31:16], host.co);
    end
  endtask
  task final_report;
    begin
      $display("compares %0d, err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    #380000;
    err_count = err_count + 1;
    $display("unexpected at %0t ns: run hung", $time);
    final_report;
  end
  // ********
  // Tests
  // ********
  initial begin
    repeat (5) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (10) @(posedge clk);
    #1 sample_valid = 1'b1;
    repeat (8) @(posedge clk);
    #1 sample_valid = 1'b0;
    @(posedge clk);
    #1 chk(sample_ready, 1'b0);
    for (k = 0; k < 4; k = k + 1) begin
      @(posedge clk) #1 word_length_field = k[1:0];
      run(`SCF_CMD_NULL, 16'h0000, st(0, 0, 0), 5, 1, 1'b0);
      chk(host.rx[1], dx(k[1:0], 24'h7F_FFFF));
      chk(host.rx[2], dx(k[1:0], 24'h80_0000));
      chk(host.rx[3], dx(k[1:0], 24'hFF_FFFF));
    end
    chk(sample_ready, 1'b1);
    @(posedge clk) #1 word_length_field = `SCF_WL_24;
    run(`SCF_CMD_STANDBY, 16'h0000, st(0, 0, 0), 5, 1, 1'b0);
    run(`SCF_CMD_STANDBY, 16'h0000, `SCF_CMD_STANDBY, 5, 1, 1'b0);
    chk(standby, 1'b1);
    run(`SCF_CMD_WAKEUP, 16'h0000, `SCF_CMD_STANDBY, 5, 1, 1'b0);
    chk(standby, 1'b0);
    run(`SCF_CMD_WAKEUP, 16'h0000, `SCF_CMD_WAKEUP, 5, 1, 1'b0);
    run(`SCF_CMD_LOCK, 16'h0000, `SCF_CMD_WAKEUP, 5, 1, 1'b0);
    chk(locked, 1'b1);
    run(`SCF_CMD_STANDBY, 16'h0000, `SCF_CMD_LOCK, 5, 1, 1'b0);
    chk(standby, 1'b0);
    run(`SCF_CMD_UNLOCK, 16'h0000, st(1, 0, 0), 5, 1, 1'b0);
    chk(locked, 1'b0);
    run(16'hA280, 16'h0000, `SCF_CMD_UNLOCK, 5, 1, 1'b0);
    run(16'hA281, 16'h0000, 16'hA5A0, 5, 1, 1'b0);
    run(16'h6180, 16'h1234, 16'hE281, 4, 2, 1'b0);
    chk(host.rx[1][31:16], 16'hA5A0);
    chk(host.rx[2][31:16], 16'hA5A3);
    chk(wr_seen, {6'h03, 16'h1234});
    run(16'h7F01, 16'hBEEF, 16'h4180, 5, 3, 1'b0);
    chk(wr_seen, {6'h3F, 16'h0000});
    @(posedge clk) #1 rx_crc_enable = 1'b1;
    run(`SCF_CMD_STANDBY, 16'h0000, 16'h5F00, 5, 1, 1'b1);
    chk(standby, 1'b0);
    chk(crc_err, 1'b1);
    run(16'h6180, 16'h5678, st(0, 1, 0), 5, 2, 1'b1);
    chk(wr_seen, {6'h03, 16'h5678});
    run(`SCF_CMD_NULL, 16'h0000, st(0, 1, 0), 5, 1, 1'b0);
    chk(crc_err, 1'b0);
    @(posedge clk) #1 crc_type_ansi = 1'b1;
    run(`SCF_CMD_NULL, 16'h0000, st(0, 0, 0), 5, 1, 1'b0);
    chk(crc_err, 1'b0);
    run(`SCF_CMD_RESET, 16'h0000, st(0, 0, 0), 5, 1, 1'b0);
    chk(resets, 1);
    repeat (100) @(posedge clk);
    run(`SCF_CMD_RESET, 16'h0000, `SCF_RESP_RESET_OK, 2, 1, 1'b0);
    run(`SCF_CMD_NULL, 16'h0000, `SCF_RESP_RESET_BAD, 5, 1, 1'b0);
    chk(resets, 1);
    @(posedge clk) #1 timeout_enable = 1'b1;
    word_length_field = `SCF_WL_32_ZERO;
    host.tx[0] = `SCF_CMD_RESET;
    host.frame(8, 32, 1, 1'b0);
    chk(host.rx[0][31:16], st(0, 0, 0));
    run(`SCF_CMD_NULL, 16'h0000, st(0, 0, 0), 5, 1, 1'b0);
    chk(resets, 1);
    run(16'h0F0F, 16'h0000, st(0, 0, 0), 5, 1, 1'b0);
    run(`SCF_CMD_NULL, 16'h0000, st(0, 0, 0), 5, 1, 1'b0);
    final_report;
  end
endmodule
